// File: design/cet_engage.sv
// cam engagement trigger and sequencer with its AXI4-Lite registers
// Overview of operation
// R01: after the command, hold the follower still until the lead passes the trigger.
// R02: lead already exactly at the trigger on command: engage at once.
// R03: trigger never reached means no engagement and no synchronisation.
// R04: fix position-to-phase mapping from shifts and gains when engagement begins.
// R05: during engagement move per profile, limited by velocity, accel and decel; with the profile bit set, only the velocity limit applies.
// R06: follower and lead cam phases match the plan: declare synchronous motion.
// R07: trigger value means axis position, axis phase or cam phase by select.
// R08: select 0: target is trigger value plus lead position at command.
// R09: select 1: trigger value is the absolute lead target position.
// R10: select 2: lead phase is position modulo axis modulo, compared with trigger.
// R11: phase triggers engage only on the first match after the command.
// R12: select 2 with trigger outside zero to modulo fails with an error.
// R13: trigger seen whether target lies above, below or at start position.
// R14: select 3: phase is position modulo cam cycle, first match engages.
// R15: zero relative trigger ramps follower to sync speed, else stop at once.
// R16: capture all command parameters at the command and use only those.
// R17: raise error output on failed execution or illegal parameters.
// R18: each period compare previous and current lead sample; crossing counts.
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module cet_engage
  import cet_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cet_sample_type lead_sample,
  input wire logic signed [31:0] follower_pos,
  output cet_drive_type follower_cmd,
  output logic busy,
  output logic in_sync,
  output logic error,
  output logic irq
);

  // ------------------------------------------------------------
  // register file and write channel
  // ------------------------------------------------------------
  logic [31:0] regs [0:9];
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire [3:0] w_idx = aw_addr[5:2];
  wire w_mapped = (aw_addr[1:0] == 2'h0) && (aw_addr <= CET_IRQ_MASK)
    && (aw_addr != CET_STATUS) && (aw_addr != CET_IRQ_STAT);
  wire [31:0] w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
    {8{w_strb[0]}}};

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CET_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_mapped ? CET_RESP_OKAY : CET_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 10; i++) begin
        regs[i] <= 32'h0000_0000;
      end
      regs[CET_CTRL[5:2]] <= CET_CTRL_RST;
      regs[CET_MODULO[5:2]] <= CET_MODULO_RST;
      regs[CET_CAM_CYCLE[5:2]] <= CET_MODULO_RST;
      regs[CET_GAINS[5:2]] <= CET_GAINS_RST;
      regs[CET_VEL_LIM[5:2]] <= CET_LIM_RST;
      regs[CET_ACC_LIM[5:2]] <= CET_LIM_RST;
      regs[CET_DEC_LIM[5:2]] <= CET_LIM_RST;
      irq_mask <= CET_MASK_RST;
    end else if (do_write && w_mapped) begin
      if (aw_addr == CET_IRQ_MASK) begin
        irq_mask <= (irq_mask & ~w_mask[2:0]) | (w_data[2:0] & w_mask[2:0]);
      end else begin
        regs[w_idx] <= (regs[w_idx] & ~w_mask) | (w_data & w_mask);
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer state and command capture
  // ------------------------------------------------------------
  cet_state_type state;
  cet_params_type cap;
  logic exec_q;
  logic signed [31:0] prev_pos;
  logic signed [31:0] target;
  logic signed [31:0] lead_base;
  logic signed [31:0] follow_base;
  wire exec_lvl = regs[CET_CTRL[5:2]][CET_CTRL_EXEC_BIT];
  wire exec_rise = exec_lvl && !exec_q;
  wire cet_select_type sel_now =
    cet_select_type'(regs[CET_CTRL[5:2]][CET_CTRL_SEL_LSB +: 2]);
  wire signed [31:0] trig_now = regs[CET_TRIG[5:2]];
  wire signed [31:0] mod_now = (sel_now == CET_SEL_CAM_PHASE) ?
    regs[CET_CAM_CYCLE[5:2]] : regs[CET_MODULO[5:2]];
  wire phase_now = sel_now[1]; // R07
  // a phase trigger needs a positive cycle and a value inside it
  wire illegal = phase_now && ((mod_now <= 0) || (trig_now < 0)
    || (trig_now >= mod_now)); // R12 R17

  // ------------------------------------------------------------
  // trigger detection
  // ------------------------------------------------------------
  function automatic logic signed [31:0] wrap_phase(
    input logic signed [31:0] p, input logic signed [31:0] m);
    logic signed [31:0] r;
    r = p % m;
    return (r < 0) ? r + m : r;
  endfunction

  wire signed [31:0] cur_pos = lead_sample.valid ? lead_sample.pos : prev_pos;
  wire cap_phase = cap.sel[1];
  wire signed [31:0] cap_mod = cap_phase ? (cap.sel == CET_SEL_CAM_PHASE ?
    cap.cam_cycle : cap.modulo) : 32'sh0000_0001;
  wire signed [31:0] cur_ph = wrap_phase(cur_pos, cap_mod); // R10 R14
  wire signed [31:0] prev_ph = wrap_phase(prev_pos, cap_mod);
  wire fwd = cur_pos > prev_pos;
  wire bwd = cur_pos < prev_pos;
  // position triggers: a crossing in either direction counts
  wire pos_hit = (cur_pos == target)
    || (prev_pos < target && cur_pos >= target)
    || (prev_pos > target && cur_pos <= target); // R13 R18
  // phase triggers: account for the phase wrapping inside one period
  wire fwd_wrap = cur_ph < prev_ph;
  wire bwd_wrap = cur_ph > prev_ph;
  wire fwd_hit = fwd && (fwd_wrap ? (target > prev_ph || target <= cur_ph)
    : (target > prev_ph && target <= cur_ph));
  wire bwd_hit = bwd && (bwd_wrap ? (target < prev_ph || target >= cur_ph)
    : (target < prev_ph && target >= cur_ph));
  wire ph_hit = (cur_ph == target) || fwd_hit || bwd_hit; // R18
  wire hit = lead_sample.valid && (cap_phase ? ph_hit : pos_hit); // R03
  // exact match at the command itself engages without waiting
  wire ph_at_exec = wrap_phase(cur_pos, mod_now) == trig_now;
  wire at_exec = phase_now ? ph_at_exec :
    (sel_now == CET_SEL_ABSOLUTE ? cur_pos == trig_now
      : trig_now == 32'sh0000_0000); // R02
  wire signed [31:0] target_now = (sel_now == CET_SEL_RELATIVE) ?
    trig_now + cur_pos : trig_now; // R08 R09

  // ------------------------------------------------------------
  // cam mapping and motion profile
  // ------------------------------------------------------------
  wire signed [31:0] lead_rel = cur_pos - lead_base;
  wire signed [48:0] lead_scaled = lead_rel * $signed({1'b0, cap.lead_gain});
  wire signed [31:0] lead_phase = lead_scaled[CET_GAIN_FRAC +: 32];
  wire signed [48:0] fol_scaled = lead_phase
    * $signed({1'b0, cap.follow_gain});
  // identity cam plan; cam table contents live outside this block
  wire signed [31:0] fol_goal = follow_base + fol_scaled[CET_GAIN_FRAC +: 32];
  wire signed [31:0] pos_err = fol_goal - follower_pos;
  wire signed [31:0] vel = follower_cmd.vel;
  wire signed [31:0] desired = (pos_err > cap.vel_lim) ? cap.vel_lim :
    (pos_err < -cap.vel_lim) ? -cap.vel_lim : pos_err;
  wire signed [31:0] up_step = (desired - vel > cap.acc_lim) ?
    vel + cap.acc_lim : desired;
  wire signed [31:0] dn_step = (vel - desired > cap.dec_lim) ?
    vel - cap.dec_lim : desired;
  wire signed [31:0] next_vel = cap.profile ? desired :
    (desired > vel ? up_step : dn_step); // R05
  wire synced = pos_err == 32'sh0000_0000; // R06

  cet_state_type next_state;
  always_comb begin
    next_state = state;
    case (state)
      CET_IDLE: if (exec_rise) begin
        next_state = illegal ? CET_FAULT
          : (at_exec ? CET_ENGAGE : CET_WAIT); // R02 R12
      end
      CET_WAIT: if (hit) next_state = CET_ENGAGE; // R01 R11
      CET_ENGAGE: if (lead_sample.valid && synced) begin
        next_state = CET_SYNC; // R06
      end
      CET_SYNC, CET_FAULT: if (!exec_lvl) next_state = CET_IDLE;
      default: next_state = CET_IDLE;
    endcase
  end

  wire enter_engage = (next_state == CET_ENGAGE) && (state != CET_ENGAGE);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CET_IDLE;
      exec_q <= 1'b0;
      cap <= '0;
      target <= 32'sh0000_0000;
      prev_pos <= 32'sh0000_0000;
      lead_base <= 32'sh0000_0000;
      follow_base <= 32'sh0000_0000;
    end else begin
      state <= next_state;
      exec_q <= exec_lvl;
      if (lead_sample.valid) begin
        prev_pos <= cur_pos;
      end
      if (state == CET_IDLE && exec_rise) begin
        cap <= '{sel: sel_now,
          profile: regs[CET_CTRL[5:2]][CET_CTRL_PROFILE_BIT],
          trig: trig_now, modulo: regs[CET_MODULO[5:2]],
          cam_cycle: regs[CET_CAM_CYCLE[5:2]],
          lead_shift: regs[CET_LEAD_SHIFT[5:2]],
          follow_shift: regs[CET_FOLLOW_SHIFT[5:2]],
          lead_gain: regs[CET_GAINS[5:2]][15:0],
          follow_gain: regs[CET_GAINS[5:2]][CET_GAIN_FOLLOW_LSB +: 16],
          vel_lim: regs[CET_VEL_LIM[5:2]],
          acc_lim: regs[CET_ACC_LIM[5:2]],
          dec_lim: regs[CET_DEC_LIM[5:2]]}; // R16
        target <= phase_now ? trig_now : target_now; // R08 R09 R07
        prev_pos <= cur_pos;
      end
      if (enter_engage) begin
        lead_base <= cur_pos + (state == CET_IDLE ?
          regs[CET_LEAD_SHIFT[5:2]] : cap.lead_shift); // R04
        follow_base <= follower_pos + (state == CET_IDLE ?
          regs[CET_FOLLOW_SHIFT[5:2]] : cap.follow_shift); // R04
      end
    end
  end

  // ------------------------------------------------------------
  // follower drive command
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      follower_cmd <= '{hold: 1'b1, vel: 32'sh0000_0000};
    end else if (next_state inside {CET_WAIT, CET_FAULT, CET_IDLE}) begin
      // stopping at once is abrupt but keeps the follower clear
      follower_cmd <= '{hold: 1'b1, vel: 32'sh0000_0000}; // R01 R15
    end else if (state == CET_ENGAGE || state == CET_SYNC) begin
      if (lead_sample.valid) begin
        follower_cmd <= '{hold: 1'b0, vel: next_vel}; // R05 R15
      end
    end else begin
      follower_cmd.hold <= 1'b0;
    end
  end

  assign busy = state != CET_IDLE;
  assign in_sync = state == CET_SYNC;
  assign error = state == CET_FAULT; // R17

  // ------------------------------------------------------------
  // interrupts and read channel
  // ------------------------------------------------------------
  wire [2:0] events;
  assign events[CET_IRQ_ENGAGE_BIT] = enter_engage;
  assign events[CET_IRQ_SYNC_BIT] = next_state == CET_SYNC && !in_sync;
  assign events[CET_IRQ_ERROR_BIT] = next_state == CET_FAULT && !error;
  wire rd_take = s_axi_arvalid && !s_axi_rvalid;
  wire [3:0] r_idx = s_axi_araddr[5:2];
  wire r_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= CET_TARGET);
  logic [31:0] r_word;
  always_comb begin
    case (s_axi_araddr)
      CET_STATUS: r_word = {27'h0, state};
      CET_IRQ_STAT: r_word = {29'h0, irq_stat};
      CET_IRQ_MASK: r_word = {29'h0, irq_mask};
      CET_TARGET: r_word = target;
      default: r_word = r_ok ? regs[r_idx] : 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 3'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CET_RESP_OKAY;
    end else begin
      // a new event in the read cycle survives the clear
      if (rd_take && s_axi_araddr == CET_IRQ_STAT) begin
        irq_stat <= events;
      end else begin
        irq_stat <= irq_stat | events;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= r_word;
        s_axi_rresp <= r_ok ? CET_RESP_OKAY : CET_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // cet_engage
`default_nettype wire

// File: design/cet_pkg.sv
// shared constants and types for the cam engagement trigger
package cet_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CET_CTRL = 8'h00;
  localparam logic [7:0] CET_TRIG = 8'h04;
  localparam logic [7:0] CET_MODULO = 8'h08;
  localparam logic [7:0] CET_CAM_CYCLE = 8'h0C;
  localparam logic [7:0] CET_LEAD_SHIFT = 8'h10;
  localparam logic [7:0] CET_FOLLOW_SHIFT = 8'h14;
  localparam logic [7:0] CET_GAINS = 8'h18;
  localparam logic [7:0] CET_VEL_LIM = 8'h1C;
  localparam logic [7:0] CET_ACC_LIM = 8'h20;
  localparam logic [7:0] CET_DEC_LIM = 8'h24;
  localparam logic [7:0] CET_STATUS = 8'h28;
  localparam logic [7:0] CET_IRQ_STAT = 8'h2C;
  localparam logic [7:0] CET_IRQ_MASK = 8'h30;
  localparam logic [7:0] CET_TARGET = 8'h34;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CET_CTRL_EXEC_BIT = 0;
  localparam int CET_CTRL_SEL_LSB = 1;
  localparam int CET_CTRL_PROFILE_BIT = 3;
  localparam int CET_GAIN_FOLLOW_LSB = 16;
  localparam int CET_GAIN_FRAC = 8;
  localparam int CET_IRQ_ENGAGE_BIT = 0;
  localparam int CET_IRQ_SYNC_BIT = 1;
  localparam int CET_IRQ_ERROR_BIT = 2;
  localparam logic [31:0] CET_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CET_MODULO_RST = 32'h0000_0168;
  localparam logic [31:0] CET_GAINS_RST = 32'h0100_0100;
  localparam logic [31:0] CET_LIM_RST = 32'h0000_0010;
  localparam logic [2:0] CET_MASK_RST = 3'h0;
  localparam logic [1:0] CET_RESP_OKAY = 2'h0;
  localparam logic [1:0] CET_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CET_SEL_RELATIVE = 2'h0,
    CET_SEL_ABSOLUTE = 2'h1,
    CET_SEL_AXIS_PHASE = 2'h2,
    CET_SEL_CAM_PHASE = 2'h3
  } cet_select_type;

  typedef enum logic [4:0] {
    CET_IDLE = 5'b00001,
    CET_WAIT = 5'b00010,
    CET_ENGAGE = 5'b00100,
    CET_SYNC = 5'b01000,
    CET_FAULT = 5'b10000
  } cet_state_type;

  typedef struct packed {
    logic valid;
    logic signed [31:0] pos;
  } cet_sample_type;

  typedef struct packed {
    logic hold;
    logic signed [31:0] vel;
  } cet_drive_type;

  typedef struct packed {
    cet_select_type sel;
    logic profile;
    logic signed [31:0] trig;
    logic signed [31:0] modulo;
    logic signed [31:0] cam_cycle;
    logic signed [31:0] lead_shift;
    logic signed [31:0] follow_shift;
    logic [15:0] lead_gain;
    logic [15:0] follow_gain;
    logic signed [31:0] vel_lim;
    logic signed [31:0] acc_lim;
    logic signed [31:0] dec_lim;
  } cet_params_type;

endpackage

// File: tb/cet_axis_model.sv
// lead axis sample source and follower axis integrator
`timescale 1ns/1ns
`default_nettype none
module cet_axis_model
  import cet_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic signed [31:0] load_pos,
  input wire logic signed [31:0] step,
  input wire cet_drive_type follower_cmd,
  output var cet_sample_type lead_sample = '0,
  output var logic signed [31:0] follower_pos = 32'h0000_0000
);
  logic [1:0] tick = 2'h0;
  logic signed [31:0] lead_pos = 32'h0000_0000;
  logic apply = 1'b0;

  // one sample every four cycles; pos is junk between samples
  always @(posedge aclk) begin
    tick <= tick + 2'h1;
    apply <= lead_sample.valid;
    lead_sample.valid <= 1'b0;
    lead_sample.pos <= ~lead_sample.pos;
    if (!aresetn || load) begin
      tick <= 2'h0;
      lead_pos <= aresetn ? load_pos : 32'h0000_0000;
    end else if (tick == 2'h3) begin
      lead_pos <= lead_pos + step;
      lead_sample.valid <= 1'b1;
      lead_sample.pos <= lead_pos + step;
    end
    // the drive applies each command over the period after it is issued
    if (!aresetn) begin
      follower_pos <= 32'h0000_0000;
    end else if (apply && !follower_cmd.hold) begin
      follower_pos <= follower_pos + follower_cmd.vel;
    end
  end
endmodule // cet_axis_model
`default_nettype wire

// File: tb/cet_engage_props.sv
// assertions on the cam engagement sequencer outputs
`timescale 1ns/1ns
`default_nettype none
module cet_engage_props
  import cet_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire cet_sample_type lead_sample,
  input wire cet_drive_type follower_cmd,
  input wire logic busy,
  input wire logic in_sync,
  input wire logic error
);
  // ------------------------------------------------------------
  // sequencer checks
  // ------------------------------------------------------------
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  idle_quiet_a: assert property (!busy |-> !in_sync && !error)
    else $error("sync or fault flag while idle");
  sync_only_a: assert property (in_sync |-> busy && !error)
    else $error("sync without busy or with fault");
  fault_busy_a: assert property (error |-> busy && !in_sync)
    else $error("fault without busy");
  fault_start_a: assert property ($rose(error) |-> !$past(busy))
    else $error("fault raised after the command was taken");
  sync_sample_a: assert property ($rose(in_sync) |->
    $past(lead_sample.valid) && $past(busy))
    else $error("sync reached without a lead sample");
  // after the first busy cycle, drive only moves on a lead sample, not between periods
  drive_period_a: assert property (busy && $past(busy) &&
    !$past(lead_sample.valid) |-> $stable(follower_cmd))
    else $error("drive changed between lead samples");
  sync_exit_a: assert property ($fell(in_sync) |-> !busy)
    else $error("sync left without going idle");
  fault_exit_a: assert property ($fell(error) |-> !busy)
    else $error("fault left without going idle");
endmodule // cet_engage_props

bind cet_engage cet_engage_props u_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .lead_sample(lead_sample),
  .follower_cmd(follower_cmd),
  .busy(busy),
  .in_sync(in_sync),
  .error(error)
);
`default_nettype wire

// File: tb/tb_cet_engage.sv
// register-level bench for the cam engagement trigger
`timescale 1ns/1ns
`default_nettype none
module tb_cet_engage
  import cet_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, m_load = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic signed [31:0] m_pos = 32'h0000_0000, m_step = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, busy, in_sync, error, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic signed [31:0] follower_pos;
  cet_sample_type lead_sample;
  cet_drive_type follower_cmd;
  int mismatches = 0;
  int compares = 0;
  logic [7:0] ra [9] = '{CET_CTRL, CET_MODULO, CET_CAM_CYCLE, CET_GAINS,
    CET_VEL_LIM, CET_ACC_LIM, CET_DEC_LIM, CET_STATUS, CET_IRQ_MASK};
  logic [31:0] rv [9] = '{CET_CTRL_RST, CET_MODULO_RST, 32'h0000_0168,
    CET_GAINS_RST, CET_LIM_RST, CET_LIM_RST, CET_LIM_RST, 32'h0000_0001,
    {29'h0, CET_MASK_RST}};

  always #4 aclk = ~aclk;

  cet_engage uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lead_sample(lead_sample),
    .follower_pos(follower_pos), .follower_cmd(follower_cmd), .busy(busy),
    .in_sync(in_sync), .error(error), .irq(irq));

  cet_axis_model u_axis (.aclk(aclk), .aresetn(aresetn), .load(m_load),
    .load_pos(m_pos), .step(m_step), .follower_cmd(follower_cmd),
    .lead_sample(lead_sample), .follower_pos(follower_pos));

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out;
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ready sampled at the falling edge, so the rising edge is the handshake
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic pa, pw, ha, hw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ha = pa && awready;
      hw = pw && wready;
      @(posedge aclk);
      pa = pa && !ha;
      pw = pw && !hw;
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    chk(32'(rresp), 32'(er));
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // engagement scenarios
  // ------------------------------------------------------------
  task run(input logic [1:0] sel, input logic [31:0] trig,
    input logic [31:0] pos, input logic [31:0] step, input logic waits,
    input logic prof);
    int n;
    @(posedge aclk);
    m_pos <= pos;
    m_load <= 1'b1;
    m_step <= 32'h0000_0000;
    @(posedge aclk);
    m_load <= 1'b0;
    wr(CET_TRIG, trig, CET_RESP_OKAY);
    wr(CET_CTRL, {28'h0, prof, sel, 1'b1}, CET_RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(CET_STATUS, CET_RESP_OKAY);
    chk(32'(d === 32'h0000_0002), 32'(waits));
    if (waits) chk(32'(follower_cmd.hold), 32'h1);
    if (sel < 2'h2) begin
      // a later trigger write must not move the captured target
      wr(CET_TRIG, trig + 32'h7, CET_RESP_OKAY);
      rd(CET_TARGET, CET_RESP_OKAY);
      chk(d, sel == 2'h0 ? pos + trig : trig);
    end
    m_step <= step;
    for (n = 0; n < 2000 && irq !== 1'b1; n++) @(negedge aclk);
    chk(32'(irq), 32'h1);
    @(posedge aclk);
    m_step <= 32'h0000_0000;
    for (n = 0; n < 2000 && in_sync !== 1'b1; n++) @(negedge aclk);
    chk(32'(in_sync), 32'h1);
    rd(CET_IRQ_STAT, CET_RESP_OKAY);
    chk(d & 32'h3, 32'h3);
    chk(32'(irq), 32'h0);
    wr(CET_CTRL, 32'h0000_0000, CET_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(busy), 32'h0);
  endtask

  task fault(input logic [1:0] sel, input logic [31:0] trig,
    input logic [31:0] mask);
    wr(CET_IRQ_MASK, mask, CET_RESP_OKAY);
    wr(CET_TRIG, trig, CET_RESP_OKAY);
    wr(CET_CTRL, {28'h0, 1'b0, sel, 1'b1}, CET_RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk(32'(error), 32'h1);
    chk(32'(irq), {31'h0, mask[2]});
    rd(CET_STATUS, CET_RESP_OKAY);
    chk(d, 32'h0000_0010);
    rd(CET_IRQ_STAT, CET_RESP_OKAY);
    chk(d & 32'h4, 32'h4);
    wr(CET_CTRL, 32'h0000_0000, CET_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(error), 32'h0);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], CET_RESP_OKAY);
      chk(d, rv[i]);
    end
    rd(8'h3C, CET_RESP_SLVERR);
    chk(d, 32'h0000_0000);
    rd(8'h02, CET_RESP_SLVERR);
    wr(CET_STATUS, 32'h0000_0008, CET_RESP_SLVERR);
    wr(CET_IRQ_MASK, 32'h0000_0001, CET_RESP_OKAY);
    rd(CET_IRQ_MASK, CET_RESP_OKAY);
    chk(d, 32'h0000_0001);
    wr(CET_FOLLOW_SHIFT, 32'h0000_0020, CET_RESP_OKAY);
    run(2'h0, 32'h28, 32'h64, 32'hA, 1'b1, 1'b0);
    chk(follower_pos, 32'h0000_0020);
    run(2'h0, 32'hFFFF_FFC4, 32'h64, 32'hFFFF_FFF6, 1'b1, 1'b1);
    run(2'h0, 32'h0, 32'hFA, 32'h0, 1'b0, 1'b0);
    run(2'h1, 32'h12C, 32'h1F4, 32'hFFFF_FFEC, 1'b1, 1'b1);
    run(2'h1, 32'h12C, 32'h12C, 32'h0, 1'b0, 1'b0);
    run(2'h2, 32'h64, 32'h3E8, 32'h14, 1'b1, 1'b0);
    run(2'h2, 32'h64, 32'h3E8, 32'hFFFF_FFEC, 1'b1, 1'b1);
    run(2'h3, 32'h64, 32'h3E8, 32'hFFFF_FFEC, 1'b1, 1'b0);
    run(2'h3, 32'h118, 32'h3E8, 32'h0, 1'b0, 1'b1);
    fault(2'h2, 32'h168, 32'h4);
    fault(2'h2, 32'hFFFF_FFFF, 32'h0);
    fault(2'h3, 32'h168, 32'h4);
    close_out;
  end

  // whole run is about a thousand cycles; this margin only cuts a hang
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    close_out;
  end
endmodule // tb_cet_engage
`default_nettype wire
